// File: verilog/acc_pkg.sv
/*
  Constants for the converter and comparator control block: register field
  positions, reset values, operation codes and sequence lengths.
  Assumes a 100 MHz machine-cycle clock; one machine cycle is one clock.
*/
package acc_pkg;
    // Register port map, word offsets
    localparam logic [1:0] ACC_OFS_CTRL = 2'h0;
    localparam logic [1:0] ACC_OFS_IRQ = 2'h1;
    localparam logic [1:0] ACC_OFS_CMPV = 2'h2;
    localparam logic [1:0] ACC_OFS_STAT = 2'h3;
    // Field positions
    localparam int ACC_MODE_BIT = 3;
    localparam int ACC_SPARE_BIT = 2;
    localparam int ACC_IRQSEL_BIT = 2;
    // Reset values
    localparam logic [3:0] ACC_CTRL_RST = 4'h0;
    localparam logic [3:0] ACC_IRQ_RST = 4'h0;
    localparam logic [7:0] ACC_CMPV_RST = 8'h00;
    localparam logic [9:0] ACC_RESULT_RST = 10'h000;
    // Sequence lengths in machine cycles, and result width in bits
    localparam int ACC_CONV_CYCLES = 62;
    localparam int ACC_CMP_CYCLES = 8;
    localparam int ACC_RES_BITS = 10;
    // Operation codes on the instruction path
    typedef enum logic [2:0] {
        ACC_OP_NONE = 3'b000,
        ACC_OP_START = 3'b001,
        ACC_OP_SKIP = 3'b010,
        ACC_OP_LOADCMP = 3'b011,
        ACC_OP_FETCHLO = 3'b100,
        ACC_OP_FETCHHI = 3'b101
    } acc_op_t;
    typedef enum logic [1:0] {
        ACC_ST_IDLE = 2'b00,
        ACC_ST_CONV = 2'b01,
        ACC_ST_CMP = 2'b10
    } acc_state_t;
endpackage

// File: verilog/acc_sar.sv
/*
  Successive-approximation result register with trial-bit stepping.
  Assumes the analog comparator answers within the step it is asked.
*/
`timescale 1ns/1ns
module acc_sar #(
    parameter int WIDTH = 10
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Control
    input wire logic clear,
    input wire logic trial,
    input wire logic decide,
    input wire logic [3:0] bit_idx,
    input wire logic ref_below_in,
    // Result
    output logic [WIDTH-1:0] result
);
    // The bit index is four bits wide
    if (WIDTH < 2 || WIDTH > 16) begin : g_bad_width
        $error("acc_sar: WIDTH out of range");
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            result <= '0;
        end else if (clear) begin
            result <= '0;
        end else if (trial) begin
            result[bit_idx] <= 1'b1;
        end else if (decide) begin
            result[bit_idx] <= ref_below_in;
        end
    end
endmodule // acc_sar

// File: verilog/acc_ctrl.sv
/*
  Control of a 10-bit successive-approximation converter that can also act
  as an 8-bit comparator: mode and input selection, start, sequencing,
  result and compare-value registers, done flag and its clearing.
  Assumes instruction ops arrive as one-cycle codes from the CPU path and
  the analog comparator answers combinationally to the DAC code.
*/
`timescale 1ns/1ns
// Behaviour
// - Mode bit one selects comparator operation
// - Comparator DAC code comes from compare value
// - Load-compare packs upper and lower work nibbles
// - Result undefined after switch to comparator
// - Compare value kept across mode changes
// - Compare value access only in comparator mode
// - Compare ends eight cycles after start
// - Done set when input below reference
// - Done cleared by interrupt or skip
// - Interrupt control bit selects interrupt or skip; skip here also answers and clears with interrupt selected
// - Fetch-low moves result bits, zeroes low bits
// - Skip after mode change clears stray done
// - Mode zero converts; bits select input
// - Conversion clears then resolves bits MSB first
// - Conversion ends 62 cycles, sets done
// - Fetch-high copies top eight result bits
module acc_ctrl #(
    parameter int CONV_CYCLES = acc_pkg::ACC_CONV_CYCLES,
    parameter int CMP_CYCLES = acc_pkg::ACC_CMP_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [1:0] reg_addr,
    input wire logic [3:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Instruction path
    input wire logic [2:0] op_code,
    input wire logic [3:0] work_upper,
    input wire logic [3:0] work_lower,
    input wire logic irq_taken,
    output logic op_skip,
    output logic work_upper_load,
    output logic work_lower_load,
    output logic [3:0] work_upper_value,
    output logic [3:0] work_lower_value,
    output logic done_irq,
    // Analog front end
    input wire logic ref_below_in,
    output logic [9:0] dac_code,
    output logic comparator_mode,
    output logic [1:0] input_select,
    output logic busy
);
    // A trial bit needs three cycles to reach the DAC through the registers, so each step
    // must be at least three cycles long
    if (CONV_CYCLES < 3 * acc_pkg::ACC_RES_BITS + 2 || CONV_CYCLES > 255 || CMP_CYCLES < 2
        || CMP_CYCLES > 255) begin : g_bad_cycles
        $error("acc_ctrl: cycle counts out of range");
    end

    localparam logic [7:0] CONV_LAST = 8'(CONV_CYCLES - 1);
    localparam logic [7:0] CMP_LAST = 8'(CMP_CYCLES - 1);
    localparam logic [7:0] STEP_LEN = 8'((CONV_CYCLES - 2) / acc_pkg::ACC_RES_BITS);

    acc_pkg::acc_state_t state;
    logic [3:0] converter_control_reg;
    logic [3:0] irq_ctl_two;
    logic [7:0] cmp_value;
    logic [7:0] cycle_cnt;
    logic [7:0] step_cnt;
    logic [3:0] bit_idx;
    logic convert_done_flag;
    logic sar_clear;
    logic sar_trial;
    logic sar_decide;
    logic [9:0] result;
    logic conv_finish;
    logic cmp_finish;
    logic set_done;
    logic clr_done;
    logic start_ok;
    logic op_start;
    logic mode_cmp;

    assign mode_cmp = converter_control_reg[acc_pkg::ACC_MODE_BIT];
    assign op_start = (op_code == acc_pkg::ACC_OP_START);
    assign start_ok = op_start && (state == acc_pkg::ACC_ST_IDLE);
    assign conv_finish = (state == acc_pkg::ACC_ST_CONV) && (cycle_cnt == CONV_LAST);
    assign cmp_finish = (state == acc_pkg::ACC_ST_CMP) && (cycle_cnt == CMP_LAST);
    assign sar_clear = start_ok && !mode_cmp;
    assign sar_trial = (state == acc_pkg::ACC_ST_CONV) && (step_cnt == 8'h00)
        && (cycle_cnt != CONV_LAST) && (bit_idx != 4'hF);
    assign sar_decide = (state == acc_pkg::ACC_ST_CONV) && (step_cnt == STEP_LEN - 8'h01)
        && (bit_idx != 4'hF);
    // Done set at end of conversion, or at end of compare if input below reference
    assign set_done = conv_finish || (cmp_finish && !ref_below_in);
    // Interrupt-routed flag clears on acceptance, skip-routed flag on a taken skip
    assign clr_done = (irq_taken && irq_ctl_two[acc_pkg::ACC_IRQSEL_BIT])
        || ((op_code == acc_pkg::ACC_OP_SKIP) && convert_done_flag);

    acc_sar #(
        .WIDTH(acc_pkg::ACC_RES_BITS)
    ) u_sar (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clear(sar_clear),
        .trial(sar_trial),
        .decide(sar_decide),
        .bit_idx(bit_idx),
        .ref_below_in(ref_below_in),
        .result(result)
    );

    // Sequencer
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state <= acc_pkg::ACC_ST_IDLE;
            cycle_cnt <= 8'h00;
        end else begin
            case (state)
                acc_pkg::ACC_ST_IDLE: begin
                    cycle_cnt <= 8'h00;
                    if (start_ok) begin
                        state <= mode_cmp ? acc_pkg::ACC_ST_CMP : acc_pkg::ACC_ST_CONV;
                    end
                end
                acc_pkg::ACC_ST_CONV: begin
                    cycle_cnt <= cycle_cnt + 8'h01;
                    if (conv_finish) begin
                        state <= acc_pkg::ACC_ST_IDLE;
                    end
                end
                acc_pkg::ACC_ST_CMP: begin
                    cycle_cnt <= cycle_cnt + 8'h01;
                    if (cmp_finish) begin
                        state <= acc_pkg::ACC_ST_IDLE;
                    end
                end
                default: begin
                    state <= acc_pkg::ACC_ST_IDLE;
                    cycle_cnt <= 8'h00;
                end
            endcase
        end
    end

    // Bit stepping; each trial bit gets STEP_LEN cycles to settle
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            step_cnt <= 8'h00;
            bit_idx <= 4'hF;
        end else if (sar_clear) begin
            step_cnt <= 8'h00;
            bit_idx <= 4'(acc_pkg::ACC_RES_BITS - 1);
        end else if (state == acc_pkg::ACC_ST_CONV && bit_idx != 4'hF) begin
            if (step_cnt == STEP_LEN - 8'h01) begin
                step_cnt <= 8'h00;
                bit_idx <= bit_idx - 4'h1;
            end else begin
                step_cnt <= step_cnt + 8'h01;
            end
        end
    end

    // Control and interrupt-select registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            converter_control_reg <= acc_pkg::ACC_CTRL_RST;
            irq_ctl_two <= acc_pkg::ACC_IRQ_RST;
        end else if (reg_wr) begin
            // Mode changes mid-operation are software's fault; the sequencer keeps its mode
            if (reg_addr == acc_pkg::ACC_OFS_CTRL) begin
                converter_control_reg <= reg_wdata;
            end
            if (reg_addr == acc_pkg::ACC_OFS_IRQ) begin
                irq_ctl_two <= reg_wdata;
            end
        end
    end

    // Compare value: separate from the result, held across mode changes
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cmp_value <= acc_pkg::ACC_CMPV_RST;
        end else if (op_code == acc_pkg::ACC_OP_LOADCMP && mode_cmp) begin
            cmp_value <= {work_upper, work_lower};
        end
    end

    // Done flag; a set in the cycle of a clear wins
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            convert_done_flag <= 1'b0;
        end else if (set_done) begin
            convert_done_flag <= 1'b1;
        end else if (clr_done) begin
            convert_done_flag <= 1'b0;
        end
    end

    // Skip answer and interrupt request
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            op_skip <= 1'b0;
            done_irq <= 1'b0;
        end else begin
            op_skip <= (op_code == acc_pkg::ACC_OP_SKIP) && convert_done_flag;
            done_irq <= convert_done_flag && irq_ctl_two[acc_pkg::ACC_IRQSEL_BIT]
                && !clr_done;
        end
    end

    // Work register transfers; fetches during conversion return the partly resolved result
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            work_upper_load <= 1'b0;
            work_lower_load <= 1'b0;
            work_upper_value <= 4'h0;
            work_lower_value <= 4'h0;
        end else begin
            work_upper_load <= (op_code == acc_pkg::ACC_OP_FETCHHI);
            work_lower_load <= (op_code == acc_pkg::ACC_OP_FETCHHI)
                || (op_code == acc_pkg::ACC_OP_FETCHLO);
            if (op_code == acc_pkg::ACC_OP_FETCHHI) begin
                work_upper_value <= result[9:6];
                work_lower_value <= result[5:2];
            end else if (op_code == acc_pkg::ACC_OP_FETCHLO) begin
                work_lower_value <= {result[1:0], 2'b00};
            end
        end
    end

    // Analog front end drive; result left as is on entering comparator mode
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            dac_code <= 10'h000;
            comparator_mode <= 1'b0;
            input_select <= 2'h0;
            busy <= 1'b0;
        end else begin
            if (mode_cmp) begin
                dac_code <= {cmp_value, 2'b00};
            end else begin
                dac_code <= result;
            end
            comparator_mode <= mode_cmp;
            input_select <= converter_control_reg[1:0];
            // Falls in the cycle the flag rises, so busy spans exactly the run length
            busy <= ((state != acc_pkg::ACC_ST_IDLE) && !conv_finish && !cmp_finish)
                || start_ok;
        end
    end

    // Register reads; compare value reads zero outside comparator mode
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                acc_pkg::ACC_OFS_CTRL: reg_rdata <= {4'h0, converter_control_reg};
                acc_pkg::ACC_OFS_IRQ: reg_rdata <= {4'h0, irq_ctl_two};
                acc_pkg::ACC_OFS_CMPV: reg_rdata <= mode_cmp ? cmp_value : 8'h00;
                acc_pkg::ACC_OFS_STAT: reg_rdata <= {5'h00, state, convert_done_flag};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule // acc_ctrl

// File: test/acc_ctrl_sva.sv
/* Port checker for acc_ctrl.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ns
module acc_ctrl_chk #(
    parameter int CONV_CYCLES = 62,
    parameter int CMP_CYCLES = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [1:0] reg_addr,
    input wire logic [3:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Instruction path
    input wire logic [2:0] op_code,
    input wire logic [3:0] work_upper,
    input wire logic [3:0] work_lower,
    input wire logic irq_taken,
    input wire logic op_skip,
    input wire logic work_upper_load,
    input wire logic work_lower_load,
    input wire logic [3:0] work_upper_value,
    input wire logic [3:0] work_lower_value,
    input wire logic done_irq,
    // Analog front end
    input wire logic [9:0] dac_code,
    input wire logic comparator_mode,
    input wire logic [1:0] input_select,
    input wire logic busy
);
    logic [7:0] busy_cnt;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Cleared while idle, so an accepted restart would show as a long run
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !busy) begin
            busy_cnt <= 8'h00;
        end else begin
            busy_cnt <= busy_cnt + 8'h01;
        end
    end
    sequence s_skip_taken;
        op_skip && !busy ##1 op_code == acc_pkg::ACC_OP_SKIP && !busy;
    endsequence
    property p_run_len;
        $fell(busy) |-> busy_cnt == (comparator_mode ? CMP_CYCLES : CONV_CYCLES);
    endproperty
    property p_skip_cause;
        op_skip |-> $past(op_code) == acc_pkg::ACC_OP_SKIP;
    endproperty
    property p_skip_clears;
        s_skip_taken |=> !op_skip;
    endproperty
    property p_irq_clear;
        irq_taken && !busy |-> ##2 !done_irq;
    endproperty
    property p_fetch_low;
        op_code == acc_pkg::ACC_OP_FETCHLO && !busy && !comparator_mode |=> work_lower_load
            && !work_upper_load && work_lower_value == {$past(dac_code[1:0]), 2'b00};
    endproperty
    property p_fetch_high;
        op_code == acc_pkg::ACC_OP_FETCHHI && !busy && !comparator_mode |=> work_upper_load
            && {work_upper_value, work_lower_value} == $past(dac_code[9:2]);
    endproperty
    property p_load_cmp;
        op_code == acc_pkg::ACC_OP_LOADCMP && comparator_mode && !busy
            |-> ##2 dac_code == {$past(work_upper, 2), $past(work_lower, 2), 2'b00};
    endproperty
    property p_mode_copy;
        reg_wr && reg_addr == acc_pkg::ACC_OFS_CTRL |-> ##2
            comparator_mode == $past(reg_wdata[3], 2) && input_select == $past(reg_wdata[1:0], 2);
    endproperty
    property p_rdata_idle;
        !$past(reg_rd) |-> reg_rdata == 8'h00;
    endproperty
    a_run_len: assert property (p_run_len) else $error("run length wrong");
    a_skip_cause: assert property (p_skip_cause) else $error("skip without op");
    a_skip_clears: assert property (p_skip_clears) else $error("flag kept");
    a_irq_clear: assert property (p_irq_clear) else $error("irq not cleared");
    a_fetch_low: assert property (p_fetch_low) else $error("fetch low wrong");
    a_fetch_high: assert property (p_fetch_high) else $error("fetch high wrong");
    a_load_cmp: assert property (p_load_cmp) else $error("compare code wrong");
    a_mode_copy: assert property (p_mode_copy) else $error("mode copy wrong");
    a_rdata_idle: assert property (p_rdata_idle) else $error("stray read data");
endmodule // acc_ctrl_chk
bind acc_ctrl acc_ctrl_chk #(.CONV_CYCLES(CONV_CYCLES), .CMP_CYCLES(CMP_CYCLES)) u_chk (.*);

// File: test/acc_afe_model.sv
/* Analog front end: ideal comparator against a level set by the bench.
   Assumes the level only moves between operations. */
`timescale 1ns/1ns
module acc_afe_model (
    // Converter side
    input wire logic [9:0] dac_code,
    input wire logic [9:0] vin_level,
    // Answer
    output logic ref_below_in
);
    // Zero delay, so settling margins of a real front end go untested
    // Pin is analog only here; its port output latch is taken as held high
    assign ref_below_in = dac_code < vin_level;
endmodule // acc_afe_model

// File: test/acc_ctrl_tb.sv
/* Bench for acc_ctrl: register and instruction sequences with expected values.
   Assumes acc_afe_model as front end and the bound checker. */
`timescale 1ns/1ns
module acc_ctrl_tb;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [3:0] reg_wdata = 4'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [2:0] op_code = 3'h0;
    logic [3:0] work_upper = 4'h0;
    logic [3:0] work_lower = 4'h0;
    logic irq_taken = 1'b0;
    logic [9:0] vin_level = 10'h000;
    logic [7:0] reg_rdata;
    logic op_skip, work_upper_load, work_lower_load, done_irq, ref_below_in;
    logic comparator_mode, busy, sk;
    logic [3:0] work_upper_value, work_lower_value;
    logic [9:0] dac_code;
    logic [1:0] input_select;
    int n_mismatch = 0;
    int comparisons = 0;
    int cyc = 0;
    int i;
    always #5 ref_clk = ~ref_clk;
    acc_ctrl uut (.*);
    acc_afe_model afe (.*);
    task chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input logic [1:0] a, input logic [3:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task rd(input logic [1:0] a, input logic [7:0] exp, input string nm);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(nm, {2'b00, reg_rdata}, {2'b00, exp});
        @(posedge ref_clk);
    endtask
    task op(input logic [2:0] c, input logic [3:0] u, input logic [3:0] l);
        op_code <= c;
        work_upper <= u;
        work_lower <= l;
        @(posedge ref_clk);
        op_code <= 3'h0;
        #1 sk = op_skip;
        @(posedge ref_clk);
    endtask
    task wrap_up;
        $display("Comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(acc_pkg::ACC_OFS_CTRL, 8'h00, "ctrl");
        wr(acc_pkg::ACC_OFS_CTRL, 4'h5);
        rd(acc_pkg::ACC_OFS_CTRL, 8'h05, "ctrl");
        chk("input", {8'h00, input_select}, 10'h001);
        vin_level <= 10'h2A6;
        op(acc_pkg::ACC_OP_START, 4'h0, 4'h0);
        chk("busy", {9'h000, busy}, 10'h001);
        op(acc_pkg::ACC_OP_START, 4'h0, 4'h0);
        for (i = 0; i < 60 && sk !== 1'b1; i++) op(acc_pkg::ACC_OP_SKIP, 4'h0, 4'h0);
        chk("conv skip", {9'h000, sk}, 10'h001);
        rd(acc_pkg::ACC_OFS_STAT, 8'h00, "status");
        op(acc_pkg::ACC_OP_FETCHLO, 4'h0, 4'h0);
        chk("low", {6'h00, work_lower_value}, 10'h004);
        op(acc_pkg::ACC_OP_FETCHHI, 4'h0, 4'h0);
        chk("high", {2'b00, work_upper_value, work_lower_value}, 10'h0A9);
        $display("Conversion test done");
        chk("idle", {9'h000, busy}, 10'h000);
        wr(acc_pkg::ACC_OFS_CTRL, 4'h8);
        @(posedge ref_clk);
        chk("mode", {9'h000, comparator_mode}, 10'h001);
        wr(acc_pkg::ACC_OFS_IRQ, 4'h4);
        rd(acc_pkg::ACC_OFS_IRQ, 8'h04, "irq ctl");
        op(acc_pkg::ACC_OP_LOADCMP, 4'h6, 4'h3);
        rd(acc_pkg::ACC_OFS_CMPV, 8'h63, "cmpv");
        chk("dac", dac_code, 10'h18C);
        vin_level <= 10'h300;
        op(acc_pkg::ACC_OP_START, 4'h0, 4'h0);
        repeat (10) @(posedge ref_clk);
        chk("above", {9'h000, done_irq}, 10'h000);
        vin_level <= 10'h100;
        op(acc_pkg::ACC_OP_START, 4'h0, 4'h0);
        repeat (10) @(posedge ref_clk);
        chk("below", {9'h000, done_irq}, 10'h001);
        irq_taken <= 1'b1;
        @(posedge ref_clk);
        irq_taken <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk("taken", {9'h000, done_irq}, 10'h000);
        wr(acc_pkg::ACC_OFS_IRQ, 4'h0);
        op(acc_pkg::ACC_OP_START, 4'h0, 4'h0);
        repeat (10) @(posedge ref_clk);
        chk("masked", {9'h000, done_irq}, 10'h000);
        op(acc_pkg::ACC_OP_SKIP, 4'h0, 4'h0);
        chk("skip", {9'h000, sk}, 10'h001);
        op(acc_pkg::ACC_OP_SKIP, 4'h0, 4'h0);
        chk("skip again", {9'h000, sk}, 10'h000);
        $display("Compare test done");
        wr(acc_pkg::ACC_OFS_CTRL, 4'h0);
        op(acc_pkg::ACC_OP_SKIP, 4'h0, 4'h0);
        rd(acc_pkg::ACC_OFS_STAT, 8'h00, "status");
        rd(acc_pkg::ACC_OFS_CMPV, 8'h00, "cmpv hidden");
        op(acc_pkg::ACC_OP_LOADCMP, 4'hF, 4'hF);
        wr(acc_pkg::ACC_OFS_CTRL, 4'h8);
        rd(acc_pkg::ACC_OFS_CMPV, 8'h63, "cmpv kept");
        $display("Mode change test done");
        wrap_up();
    end
endmodule // acc_ctrl_tb
